// file: inc/lcdst_regs.svh
/*
 holds register indices, field positions, reset values and counts of the
 display scan-timing block; assumes inclusion by bare name before the package.
*/
// Functional notes
// - lcd mode: clock choice 0 takes rtc, 1 takes slow internal oscillator
// - led modes ignore clock choice and run from the system clock
// - mode 00 off, 01 lcd, 10 led external drive, 11 led direct drive
// - lcd pixel rate is oscillator over divider plus one
// - led pixel rate is system clock over 256 over divider plus one
// - divider bits 7:0 from low register, 11:8 from high register nibble
// - pin selects for commons 7,6,5,4: 1 common, 0 segments 28,29,30,31
// - blanking forces all common and segment outputs off while scan timing keeps running
// - frame flag set by hardware at end of each complete scan
// - writing 0 clears frame flag at next display clock edge
// - frame interrupt enable gates flag onto the interrupt request
// - lcd and led external: frame is one pixel period per common phase
// - led direct: frame is pixel period times active digit count
// - lcd mode keeps scanning while the chip is stopped or asleep
// - duty static through 1/8, bias 1/2, 1/3 or 1/4 selectable
// - array up to 8 commons by 28 segments, or 4 commons by 32 segments
// - brightness level field, its top bit in the high divider register
// - slow divider allows frame rates down to 1 hz
// - duty code 0000 static, 0001..0111 for 1/2..1/8
// - direct drive digits equal digit field plus one, from segment 0
`ifndef LCDST_REGS_SVH
`define LCDST_REGS_SVH

`define LCDST_IDX_DIV_LO 16'ha120
`define LCDST_IDX_DIV_HI 16'ha121
`define LCDST_IDX_CFG_A 16'ha122
`define LCDST_IDX_CFG_B 16'ha123

`define LCDST_RST_DIV_LO 8'h00
`define LCDST_RST_DIV_HI 8'h00
`define LCDST_RST_CFG_A 8'h00
`define LCDST_RST_CFG_B 8'h00

// high divider register
`define LCDST_HI_CLK_CHOICE 7
`define LCDST_HI_MODE_LSB 5
`define LCDST_HI_BRT2 4
// config a
`define LCDST_A_PIN_SEL_LSB 4
`define LCDST_A_BLANK 3
`define LCDST_A_IRQ_EN 1
`define LCDST_A_FLAG 0
// config b
`define LCDST_B_BIAS_LSB 6
`define LCDST_B_BRT_LSB 4

`define LCDST_LED_PRESCALE 256
`define LCDST_MAX_DUTY_CODE 4'h7

`define LCDST_RESP_OKAY 2'h0
`define LCDST_RESP_SLVERR 2'h2

`endif

// file: inc/lcdst_pkg.sv
/*
 types of the display scan-timing block; assumes lcdst_regs.svh is on the
 include path.
*/
package lcdst_pkg;
    typedef enum logic [1:0] {
        LCDST_MODE_OFF = 2'h0,
        LCDST_MODE_LCD = 2'h1,
        LCDST_MODE_LED_EXT = 2'h2,
        LCDST_MODE_LED_DIR = 2'h3
    } lcdst_mode_t;

    typedef struct packed {
        logic [1:0] bias;
        logic [2:0] brightness;
        logic [3:0] duty_or_digits;
        logic display_blank;
        logic frame_irq_enable;
        logic [3:0] pin_select;
        logic display_clock_choice;
        lcdst_mode_t mode;
        logic [11:0] pixel_divider_full;
    } lcdst_cfg_t;
endpackage

// file: design/lcdst_top.sv
/*
 scan-timing core of a segment display controller with an axi4-lite register
 slave. assumes rtc_tick and slow_internal_osc_tick are one-cycle strobes synchronous to
 aclk, one per oscillator rising edge, and seg_pattern is the segment data for
 the phase shown on scan_phase.
*/
`include "lcdst_regs.svh"

module lcdst_top import lcdst_pkg::*; #(
    parameter int ADDR_W = 20,
    parameter int SEG_N = 32,
    parameter int COM_N = 8,
    parameter int DIV_W = 12,
    parameter int PRE_W = 8
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // oscillator strobes and power state
    input wire logic rtc_tick,
    input wire logic slow_internal_osc_tick,
    input wire logic low_power_stop,
    // display data
    input wire logic [SEG_N-1:0] seg_pattern,
    output logic [3:0] scan_phase,
    // panel drive
    output logic [COM_N-1:0] com_out,
    output logic [SEG_N-1:0] seg_out,
    output logic [3:0] shared_is_common,
    output logic [1:0] bias_select,
    output logic [2:0] brightness_level,
    // processor
    output logic frame_irq
);

    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(`LCDST_LED_PRESCALE - 1);

    // register state
    logic [7:0] div_lo_q;
    logic [7:0] div_hi_q;
    logic [7:0] cfg_a_q;
    logic [7:0] cfg_b_q;
    logic frame_flag_q;
    logic clr_pend_q;
    lcdst_cfg_t cfg;

    // bus state
    logic aw_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic w_hold_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // scan state
    logic [PRE_W-1:0] pre_cnt_q;
    logic [DIV_W-1:0] div_cnt_q;
    logic [3:0] phase_q;
    logic [COM_N-1:0] com_q;
    logic [SEG_N-1:0] seg_q;
    logic [COM_N-1:0] com_d;
    logic [SEG_N-1:0] seg_d;
    logic irq_q;

    logic do_write;
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic disp_tick;
    logic div_src;
    logic pix_tick;
    logic [3:0] phase_last;
    logic frame_end;
    logic [COM_N-1:0] com_keep;
    logic [SEG_N-1:0] seg_keep;

    // one-hot select of the four registers, zero when unmapped
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-3:0] idx;
        idx = addr[ADDR_W-1:2];
        decode = 4'h0;
        if (idx == (ADDR_W-2)'(`LCDST_IDX_DIV_LO)) decode = 4'h1;
        if (idx == (ADDR_W-2)'(`LCDST_IDX_DIV_HI)) decode = 4'h2;
        if (idx == (ADDR_W-2)'(`LCDST_IDX_CFG_A)) decode = 4'h4;
        if (idx == (ADDR_W-2)'(`LCDST_IDX_CFG_B)) decode = 4'h8;
    endfunction

    assign cfg.pixel_divider_full = {div_hi_q[3:0], div_lo_q};
    assign cfg.mode = lcdst_mode_t'(div_hi_q[`LCDST_HI_MODE_LSB +: 2]);
    assign cfg.display_clock_choice = div_hi_q[`LCDST_HI_CLK_CHOICE];
    assign cfg.pin_select = cfg_a_q[`LCDST_A_PIN_SEL_LSB +: 4];
    assign cfg.display_blank = cfg_a_q[`LCDST_A_BLANK];
    assign cfg.frame_irq_enable = cfg_a_q[`LCDST_A_IRQ_EN];
    assign cfg.duty_or_digits = cfg_b_q[3:0];
    assign cfg.brightness = {div_hi_q[`LCDST_HI_BRT2], cfg_b_q[`LCDST_B_BRT_LSB +: 2]};
    assign cfg.bias = cfg_b_q[`LCDST_B_BIAS_LSB +: 2];

    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
    assign wsel = decode(awaddr_q);
    assign rsel = decode(s_axi_araddr);

    // write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            awready_q <= 1'b1;
            awaddr_q <= '0;
        end else if (clk_en) begin
            if (s_axi_awvalid && awready_q) begin
                aw_hold_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_q <= 1'b0;
            end else if (bvalid_q && s_axi_bready) begin
                awready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            wready_q <= 1'b1;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_wvalid && wready_q) begin
                w_hold_q <= 1'b1;
                wready_q <= 1'b0;
                wbyte_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_hold_q <= 1'b0;
            end else if (bvalid_q && s_axi_bready) begin
                wready_q <= 1'b1;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `LCDST_RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wsel == 4'h0) ? `LCDST_RESP_SLVERR : `LCDST_RESP_OKAY;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // register writes; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_lo_q <= `LCDST_RST_DIV_LO;
            div_hi_q <= `LCDST_RST_DIV_HI;
            cfg_a_q <= `LCDST_RST_CFG_A;
            cfg_b_q <= `LCDST_RST_CFG_B;
        end else if (clk_en && do_write && wlane_q) begin
            if (wsel[0]) div_lo_q <= wbyte_q;
            if (wsel[1]) div_hi_q <= wbyte_q;
            if (wsel[2]) cfg_a_q <= {wbyte_q[7:3], 1'b0, wbyte_q[1], 1'b0};
            if (wsel[3]) cfg_b_q <= wbyte_q;
        end
    end

    // read channel, answered one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `LCDST_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && arready_q) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q <= (rsel == 4'h0) ? `LCDST_RESP_SLVERR : `LCDST_RESP_OKAY;
                unique case (1'b1)
                    rsel[0]: rdata_q <= {24'h000000, div_lo_q};
                    rsel[1]: rdata_q <= {24'h000000, div_hi_q};
                    rsel[2]: rdata_q <= {24'h000000, cfg_a_q[7:1], frame_flag_q};
                    rsel[3]: rdata_q <= {24'h000000, cfg_b_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // display clock: oscillator strobes in lcd, every system cycle in led unless low_power_stop
    always_comb begin
        disp_tick = 1'b0;
        unique case (cfg.mode)
            LCDST_MODE_LCD: disp_tick = cfg.display_clock_choice ? slow_internal_osc_tick : rtc_tick;
            LCDST_MODE_LED_EXT, LCDST_MODE_LED_DIR: disp_tick = !low_power_stop;
            LCDST_MODE_OFF: disp_tick = 1'b0;
        endcase
    end

    // fixed 256 prescale feeds the divider in led modes only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_q <= '0;
        end else if (clk_en) begin
            if (cfg.mode == LCDST_MODE_LCD || cfg.mode == LCDST_MODE_OFF) begin
                pre_cnt_q <= '0;
            end else if (disp_tick) begin
                pre_cnt_q <= pre_cnt_q + 1'b1;
            end
        end
    end

    assign div_src = (cfg.mode == LCDST_MODE_LCD) ? disp_tick
                   : (disp_tick && pre_cnt_q == PRE_LAST);
    // >= so that a divider lowered mid-count cannot overrun a full wrap
    assign pix_tick = div_src && (div_cnt_q >= cfg.pixel_divider_full);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= '0;
        end else if (clk_en) begin
            if (cfg.mode == LCDST_MODE_OFF || pix_tick) begin
                div_cnt_q <= '0;
            end else if (div_src) begin
                div_cnt_q <= div_cnt_q + 1'b1;
            end
        end
    end

    // phases per frame: commons of the duty, or active digits
    always_comb begin
        phase_last = 4'h0;
        unique case (cfg.mode)
            LCDST_MODE_LED_DIR: phase_last = cfg.duty_or_digits;
            LCDST_MODE_LCD, LCDST_MODE_LED_EXT: begin
                // reserved duty codes above 1/8 clamp to 1/8
                if (cfg.duty_or_digits > `LCDST_MAX_DUTY_CODE) begin
                    phase_last = `LCDST_MAX_DUTY_CODE;
                end else begin
                    phase_last = cfg.duty_or_digits;
                end
            end
            LCDST_MODE_OFF: phase_last = 4'h0;
        endcase
    end

    assign frame_end = pix_tick && (phase_q >= phase_last);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= 4'h0;
        end else if (clk_en) begin
            if (cfg.mode == LCDST_MODE_OFF || frame_end) begin
                phase_q <= 4'h0;
            end else if (pix_tick) begin
                phase_q <= phase_q + 1'b1;
            end
        end
    end

    // frame flag; a frame end in the clearing tick wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_flag_q <= 1'b0;
        end else if (clk_en && disp_tick) begin
            if (frame_end) begin
                frame_flag_q <= 1'b1;
            end else if (clr_pend_q) begin
                frame_flag_q <= 1'b0;
            end
        end
    end

    // a clear waits for the display clock; held while the mode is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clr_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (do_write && wlane_q && wsel[2] && !wbyte_q[`LCDST_A_FLAG]) begin
                clr_pend_q <= 1'b1;
            end else if (disp_tick) begin
                clr_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= frame_flag_q && cfg.frame_irq_enable;
        end
    end

    // shared pins: common 7-k against segment 28+k
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_shared
            assign com_keep[COM_N-1-k] = cfg.pin_select[3-k];
            assign seg_keep[28+k] = !cfg.pin_select[3-k];
        end
    endgenerate
    assign com_keep[COM_N-5:0] = '1;
    assign seg_keep[27:0] = '1;

    always_comb begin
        com_d = '0;
        seg_d = '0;
        unique case (cfg.mode)
            LCDST_MODE_LCD, LCDST_MODE_LED_EXT: begin
                com_d[phase_q[2:0]] = 1'b1;
                seg_d = seg_pattern;
            end
            LCDST_MODE_LED_DIR: begin
                seg_d[phase_q] = 1'b1;
                com_d = seg_pattern[COM_N-1:0];
            end
            LCDST_MODE_OFF: begin
                com_d = '0;
                seg_d = '0;
            end
        endcase
        if (cfg.display_blank) begin
            com_d = '0;
            seg_d = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            com_q <= '0;
            seg_q <= '0;
        end else if (clk_en) begin
            com_q <= com_d & com_keep;
            seg_q <= seg_d & seg_keep;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign scan_phase = phase_q;
    assign com_out = com_q;
    assign seg_out = seg_q;
    assign shared_is_common = cfg_a_q[`LCDST_A_PIN_SEL_LSB +: 4];
    assign bias_select = cfg.bias;
    assign brightness_level = cfg.brightness;
    assign frame_irq = irq_q;

endmodule

// file: test/lcdst_top_sva.sv
/*
 checker of the bus handshake and scan ports of lcdst_top.
 assumes single clock aclk and synchronous active-low aresetn.
*/
module lcdst_top_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // display
    input wire logic [3:0] scan_phase,
    input wire logic [7:0] com_out,
    input wire logic [3:0] shared_is_common,
    input wire logic frame_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
        else $error("read answer late");
    AST_AW_DROP: assert property (s_axi_awvalid && s_axi_awready && clk_en |=> !s_axi_awready)
        else $error("awready stayed high");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && clk_en ##1 clk_en |=> s_axi_bvalid)
        else $error("write answer late");
    AST_PIN_SEL: assert property ($changed(shared_is_common) |-> $rose(s_axi_bvalid))
        else $error("pin select moved without a write");
    AST_PHASE_STEP: assert property ($changed(scan_phase)
        |-> scan_phase == 4'h0 || scan_phase == $past(scan_phase) + 4'h1)
        else $error("scan phase skipped");
    AST_FREEZE: assert property (!clk_en |=> $stable(scan_phase) && $stable(frame_irq)
        && $stable(com_out))
        else $error("state moved while frozen");

    cover property ($rose(frame_irq));
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (!clk_en ##1 clk_en);
endmodule

bind lcdst_top lcdst_top_sva i_sva (.*);

// file: test/lcdst_glass.sv
/*
 panel partner: supplies segment data for the phase being scanned.
 assumes scan_phase from the block under test.
*/
module lcdst_glass (
    // scan side
    input wire logic [3:0] scan_phase,
    output logic [31:0] seg_pattern
);
    timeunit 1ns;
    timeprecision 1ps;
    // data differs per phase so a stuck phase shows on the pins
    assign seg_pattern = {24'h5a3c9e, 4'hd, scan_phase};
endmodule

// file: test/lcdst_top_test.sv
/*
 self-checking bench of lcdst_top with the panel partner.
 assumes register bus and oscillator strobes driven here at aclk.
*/
`include "lcdst_regs.svh"

module lcdst_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] A_LO = {2'b00, `LCDST_IDX_DIV_LO, 2'b00};
    localparam logic [19:0] A_HI = {2'b00, `LCDST_IDX_DIV_HI, 2'b00};
    localparam logic [19:0] A_CA = {2'b00, `LCDST_IDX_CFG_A, 2'b00};
    localparam logic [19:0] A_CB = {2'b00, `LCDST_IDX_CFG_B, 2'b00};
    localparam logic [19:0] A_BAD = {2'b00, 16'ha12f, 2'b00};
    localparam logic [1:0] OK = `LCDST_RESP_OKAY;
    logic aclk = 0, aresetn = 0, clk_en = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [19:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, seg_pattern, seg_out;
    logic [3:0] s_axi_wstrb = 4'h1, scan_phase, shared_is_common;
    logic [1:0] s_axi_bresp, s_axi_rresp, bias_select;
    logic rtc_tick = 0, slow_internal_osc_tick = 0, low_power_stop = 0, frame_irq;
    logic [7:0] com_out;
    logic [2:0] brightness_level;
    logic rtc_on = 0, sio_on = 0;
    int tc = 0, rtc_n = 0, sio_n = 0, errors = 0, n_compared = 0;

    lcdst_top i_dut (.*);
    lcdst_glass i_glass (.scan_phase(scan_phase), .seg_pattern(seg_pattern));

    always #2.5 aclk = ~aclk;
    // strobes on unrelated cadences so the chosen source is visible
    always @(posedge aclk) begin
        tc <= tc + 1;
        if (rtc_tick) rtc_n <= rtc_n + 1;
        if (slow_internal_osc_tick) sio_n <= sio_n + 1;
        rtc_tick <= rtc_on && (tc % 4 == 0);
        slow_internal_osc_tick <= sio_on && (tc % 3 == 1);
    end

    task automatic summarize;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic lim(input int n);
        if (n >= 2000) begin
            errors++;
            $display("unexpected at %0t: wait ran out", $time);
            summarize();
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awvalid <= 1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1;
        s_axi_wdata <= {24'h0, d};
        s_axi_bready <= 1;
        for (n = 0; n < 2000 && s_axi_bvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end
        lim(n);
        s_axi_bready <= 0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_arvalid <= 1;
        s_axi_araddr <= a;
        s_axi_rready <= 1;
        for (n = 0; n < 2000 && s_axi_rvalid !== 1'b1; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end
        lim(n);
        s_axi_rready <= 0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    task automatic wait_change(output int c);
        logic [3:0] p;
        p = scan_phase;
        for (c = 0; c < 2000 && scan_phase === p; c++) begin
            @(posedge aclk);
            #1;
        end
        lim(c);
    endtask
    task automatic wait_irq(input logic v);
        int c;
        for (c = 0; c < 2000 && frame_irq !== v; c++) begin
            @(posedge aclk);
            #1;
        end
        lim(c);
    endtask
    task automatic settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask

    task automatic t_regs;
        for (int i = 0; i < 4; i++) rd(A_LO + 20'(4 * i), 32'h0, OK);
        chk(32'(frame_irq), 32'h0);
        wr(A_HI, 8'h9f, OK);
        rd(A_HI, 32'h9f, OK);
        wr(A_LO, 8'h5a, OK);
        rd(A_LO, 32'h5a, OK);
        wr(A_CB, 8'hd5, OK);
        chk(32'(bias_select), 32'h3);
        chk(32'(brightness_level), 32'h5);
        wr(A_CA, 8'hff, OK);
        rd(A_CA, 32'hfa, OK);
        chk(32'(shared_is_common), 32'hf);
        wr(A_CA, 8'h50, OK);
        chk(32'(shared_is_common), 32'h5);
        wr(A_BAD, 8'h11, `LCDST_RESP_SLVERR);
        rd(A_BAD, 32'h0, `LCDST_RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(A_LO, 8'h00, OK);
        rd(A_LO, 32'h5a, OK);
        s_axi_wstrb <= 4'h1;
        wr(A_LO, 8'h00, OK);
        wr(A_CA, 8'h00, OK);
    endtask
    task automatic t_led_ext;
        int c, c0;
        wr(A_CB, 8'h01, OK);
        wr(A_HI, 8'hc0, OK); // choice bit set, no strobes running
        wr(A_CA, 8'h02, OK);
        wait_change(c);
        wait_change(c);
        chk(32'(c), 32'd256);
        settle();
        chk(32'(com_out), 32'(8'h01 << scan_phase));
        chk(seg_out, {24'h5a3c9e, 4'hd, scan_phase});
        // flag may already be up here; time from a fresh rise
        wr(A_CA, 8'h02, OK);
        wait_irq(0);
        wait_irq(1);
        c0 = tc;
        wr(A_CA, 8'h02, OK);
        wait_irq(0);
        wait_irq(1);
        chk(32'(tc - c0), 32'd512);
        wr(A_CA, 8'h00, OK);
        repeat (600) @(posedge aclk);
        #1;
        chk(32'(frame_irq), 32'h0);
        rd(A_CA, 32'h01, OK);
        @(posedge aclk);
        clk_en <= 0;
        repeat (3) @(posedge aclk);
        clk_en <= 1;
        wr(A_CA, 8'h08, OK);
        wait_change(c);
        wait_change(c);
        chk(32'(c), 32'd256);
        settle();
        chk(32'(com_out), 32'h0);
        chk(seg_out, 32'h0);
        wr(A_CA, 8'h00, OK);
        low_power_stop <= 1;
        settle();
        c0 = 32'(scan_phase);
        repeat (600) @(posedge aclk);
        #1;
        chk(32'(scan_phase), 32'(c0));
    endtask
    task automatic t_led_dir;
        int c, c0;
        low_power_stop <= 0;
        wr(A_CB, 8'h02, OK);
        wr(A_HI, 8'h60, OK);
        wr(A_CA, 8'h02, OK);
        wait_irq(1);
        c0 = tc;
        wr(A_CA, 8'h02, OK);
        wait_irq(0);
        wait_irq(1);
        chk(32'(tc - c0), 32'd768);
        wait_change(c);
        settle();
        chk(seg_out, 32'h1 << scan_phase);
        chk(32'(com_out), {28'h0, scan_phase});
        chk(32'(scan_phase < 4'h3), 32'h1);
    endtask
    task automatic t_lcd;
        int c, r0;
        low_power_stop <= 1; // chip asleep, lcd keeps scanning
        rtc_on <= 1;
        sio_on <= 1;
        wr(A_CB, 8'h02, OK);
        wr(A_LO, 8'h02, OK);
        wr(A_HI, 8'h20, OK);
        wait_change(c);
        r0 = rtc_n;
        wait_change(c);
        chk(32'(rtc_n - r0), 32'd3);
        wr(A_HI, 8'ha0, OK);
        wait_change(c);
        r0 = sio_n;
        wait_change(c);
        chk(32'(sio_n - r0), 32'd3);
        wr(A_HI, 8'h00, OK);
        settle();
        r0 = 32'(scan_phase);
        repeat (600) @(posedge aclk);
        #1;
        chk(32'(scan_phase), 32'(r0));
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        t_regs();
        t_led_ext();
        t_led_dir();
        t_lcd();
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(A_HI, 32'h0, OK);
        summarize();
    end
endmodule
